// File: dv/bbm_exec_chk.sv
`timescale 1ns/1ps
`include "bbm_map.vh"
module bbm_exec_chk (
    input wire        clk_in,
    input wire        rst_b_in,
    input wire [5:0]  avs_address_in,
    input wire        avs_read_in,
    input wire        avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [31:0] avs_readdata_out,
    input wire        avs_waitrequest_out,
    input wire        busy_out,
    input wire        branch_taken_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    wire req_seen = avs_read_in | avs_write_in;
    wire ack_seen = req_seen & ~avs_waitrequest_out;
    chk_wait_one: assert property (
        req_seen && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("no answer after one wait cycle");
    chk_wait_pulse: assert property (
        !avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low longer than one cycle");
    chk_idle_hold: assert property (
        !req_seen && avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("answer without request");
    chk_start_busy: assert property (
        avs_write_in && !avs_waitrequest_out && !busy_out
        && avs_address_in == `BBM_OFS_CMD && avs_writedata_in[8]
        |=> busy_out) else $error("start did not raise busy");
    chk_busy_len: assert property (
        $rose(busy_out) |=> busy_out ##1 !busy_out)
        else $error("busy not two cycles");
    chk_taken_at_end: assert property (
        $rose(branch_taken_out) |-> $fell(busy_out))
        else $error("branch flag rose outside execution");
    chk_taken_clear: assert property (
        $rose(busy_out) |=> !branch_taken_out)
        else $error("branch flag not cleared at start");
    chk_unmapped_rd: assert property (
        ack_seen && avs_read_in && avs_address_in > `BBM_OFS_STATUS
        |-> avs_readdata_out == 32'h0) else $error("unmapped read not 0");
    chk_char_width: assert property (
        ack_seen && avs_read_in && avs_address_in == `BBM_OFS_MDATA
        |-> avs_readdata_out[31:8] == 24'h0) else $error("char upper bits");
    cover property ($rose(branch_taken_out));
    cover property ($fell(busy_out) && !branch_taken_out);
    cover property (ack_seen && avs_read_in);
endmodule // bbm_exec_chk
bind bbm_exec bbm_exec_chk u_chk (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .busy_out(busy_out),
    .branch_taken_out(branch_taken_out));

// File: dv/bbm_mem_ref.sv
`timescale 1ns/1ps
`include "bbm_map.vh"
module bbm_mem_ref;
    reg [7:0] m [0:4095];
    // Only the one mark bit moves; data bits are never touched
    task apply(input [11:0] a, input integer op);
        case (op)
            1: m[a][`BBM_MD_WM] = 1'b1;
            2: m[a][`BBM_MD_IM] = 1'b1;
            3: m[a][`BBM_MD_WM] = 1'b0;
            default: m[a][`BBM_MD_IM] = 1'b0;
        endcase
    endtask
endmodule // bbm_mem_ref

// File: dv/branch_bit_and_mark_exec_tb_top.sv
`timescale 1ns/1ps
`include "bbm_map.vh"
module branch_bit_and_mark_exec_tb_top;
    reg         clk_in, rst_b_in, avs_read_in, avs_write_in;
    reg  [5:0]  avs_address_in;
    reg  [31:0] avs_writedata_in, rdat;
    wire [31:0] avs_readdata_out;
    wire        avs_waitrequest_out, busy_out, branch_taken_out;
    integer     error_cnt, n_checks, op, fmt;
    bbm_exec u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .busy_out(busy_out),
        .branch_taken_out(branch_taken_out));
    bbm_mem_ref u_ref ();
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    task tally_and_finish;
        if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task fail(input [31:0] g, e);
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
    endtask
    // Request held until waitrequest is seen low at an edge
    task xfer(input rw, input [5:0] a, input [31:0] d);
        integer i;
        @(posedge clk_in);
        avs_read_in <= !rw;
        avs_write_in <= rw;
        avs_address_in <= a;
        avs_writedata_in <= d;
        i = 0;
        do begin
            @(posedge clk_in);
            i = i + 1;
        end while (avs_waitrequest_out !== 1'b0 && i < 50);
        rdat = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        if (avs_waitrequest_out !== 1'b0) begin
            fail(i, 0);
            tally_and_finish;
        end
    endtask
    task chk(input [31:0] g, e);
        n_checks = n_checks + 1;
        if (g !== e) fail(g, e);
    endtask
    task setm(input [11:0] a, input [7:0] c);
        xfer(1, `BBM_OFS_MADDR, a);
        xfer(1, `BBM_OFS_MDATA, c);
        u_ref.m[a] = c;
    endtask
    task getm(input [11:0] a);
        xfer(1, `BBM_OFS_MADDR, a);
        xfer(0, `BBM_OFS_MDATA, 0);
        chk(rdat, u_ref.m[a]);
    endtask
    // Poll is bounded; a stuck busy ends the run
    task run(input [2:0] o, input [1:0] f);
        integer i;
        xfer(1, `BBM_OFS_CMD, {23'h0, 1'b1, 2'h0, f, 1'b0, o});
        i = 0;
        do begin
            xfer(0, `BBM_OFS_STATUS, 0);
            i = i + 1;
        end while (rdat[0] !== 1'b0 && i < 10);
        if (rdat[0] !== 1'b0) begin
            fail(rdat, 0);
            tally_and_finish;
        end
    endtask
    task rdchk(input [5:0] a, input [31:0] e);
        xfer(0, a, 0);
        chk(rdat, e);
    endtask
    initial begin
        error_cnt = 0;
        n_checks = 0;
        rst_b_in = 1'b0;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_address_in = 6'h00;
        avs_writedata_in = 32'h0;
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        setm(12'h100, 8'h4A);
        xfer(1, `BBM_OFS_SEQ, 32'h0200);
        xfer(1, `BBM_OFS_AADDR, 32'h7000);
        xfer(1, `BBM_OFS_BADDR, 32'h0);
        xfer(1, `BBM_OFS_AFIELD, 32'h050);
        xfer(1, `BBM_OFS_BFIELD, 32'h100);
        xfer(1, `BBM_OFS_VFIELD, 32'h02);
        run(3'h0, 2'h0);
        rdchk(`BBM_OFS_STATUS, 32'h4 | 32'h2);
        chk(branch_taken_out, 32'h1);
        chk(busy_out, 32'h0);
        rdchk(`BBM_OFS_AADDR, 32'h7050);
        rdchk(`BBM_OFS_BADDR, 32'h0200);
        rdchk(`BBM_OFS_SEQ, 32'h7050);
        getm(12'h100);
        // Only the marks set, every variant bit on
        setm(12'h100, 8'hC0);
        xfer(1, `BBM_OFS_VFIELD, 32'h3F);
        run(3'h0, 2'h0);
        rdchk(`BBM_OFS_STATUS, 32'h4);
        chk(branch_taken_out, 32'h0);
        rdchk(`BBM_OFS_BADDR, 32'h00FF);
        rdchk(`BBM_OFS_SEQ, 32'h7050);
        setm(12'h100, 8'h01);
        xfer(1, `BBM_OFS_VFIELD, 32'h0);
        run(3'h0, 2'h1);
        rdchk(`BBM_OFS_STATUS, 32'h6);
        setm(12'h300, 8'h20);
        xfer(1, `BBM_OFS_BADDR, 32'h0300);
        xfer(1, `BBM_OFS_AADDR, 32'h0123);
        xfer(1, `BBM_OFS_SEQ, 32'h0456);
        run(3'h0, 2'h3);
        rdchk(`BBM_OFS_SEQ, 32'h0123);
        rdchk(`BBM_OFS_BADDR, 32'h0456);
        // Format c gets decoy fields to prove they go unused
        for (op = 1; op < 5; op = op + 1) begin
            for (fmt = 0; fmt < 3; fmt = fmt + 1) begin
                setm(12'h010, op < 3 ? 8'h25 : 8'hE5);
                setm(12'h011, op < 3 ? 8'h25 : 8'hE5);
                xfer(1, `BBM_OFS_AADDR, fmt == 2 ? 32'h010 : 32'h0);
                xfer(1, `BBM_OFS_BADDR, fmt == 2 ? 32'h011 : 32'h0);
                xfer(1, `BBM_OFS_AFIELD, fmt == 2 ? 32'h0AA : 32'h010);
                xfer(1, `BBM_OFS_BFIELD, fmt == 2 ? 32'h0AB : 32'h011);
                run(op[2:0], fmt[1:0]);
                u_ref.apply(12'h010, op);
                if (fmt != 1) u_ref.apply(12'h011, op);
                getm(12'h010);
                getm(12'h011);
                rdchk(`BBM_OFS_AADDR, 32'h00F);
                rdchk(`BBM_OFS_BADDR, fmt == 1 ? 32'h00F : 32'h010);
            end
        end
        rdchk(6'h3C, 32'h0);
        tally_and_finish;
    end
endmodule // branch_bit_and_mark_exec_tb_top

// File: include/bbm_map.vh
`ifndef BBM_MAP_VH
`define BBM_MAP_VH

// Register byte offsets
`define BBM_OFS_CMD      6'h00
`define BBM_OFS_AFIELD   6'h04
`define BBM_OFS_BFIELD   6'h08
`define BBM_OFS_VFIELD   6'h0C
`define BBM_OFS_SEQ      6'h10
`define BBM_OFS_AADDR    6'h14
`define BBM_OFS_BADDR    6'h18
`define BBM_OFS_VREG     6'h1C
`define BBM_OFS_MADDR    6'h20
`define BBM_OFS_MDATA    6'h24
`define BBM_OFS_STATUS   6'h28

// Command register fields
`define BBM_CMD_OP_LO    0
`define BBM_CMD_OP_HI    2
`define BBM_CMD_FMT_LO   4
`define BBM_CMD_FMT_HI   5
`define BBM_CMD_START    8

// Memory data word fields
`define BBM_MD_DATA_HI   5
`define BBM_MD_WM        6
`define BBM_MD_IM        7

// Status fields
`define BBM_ST_BUSY      0
`define BBM_ST_TAKEN     1
`define BBM_ST_DONE      2

// Operations
`define BBM_OP_BBA       3'h0
`define BBM_OP_SWM       3'h1
`define BBM_OP_SIM       3'h2
`define BBM_OP_CWM       3'h3
`define BBM_OP_CIM       3'h4

// Formats
`define BBM_FMT_A        2'h0
`define BBM_FMT_B        2'h1
`define BBM_FMT_C        2'h2
`define BBM_FMT_D        2'h3

// Reset values
`define BBM_RST_ADDR     15'h0000
`define BBM_RST_CHAR     6'h00

`endif

// File: rtl/bbm_exec.v
// What this block does
// RQ1 - Nonzero AND of char and variant branches
// RQ2 - Zero product continues in sequence
// RQ3 - Formats without variant reuse retained variant
// RQ4 - Formats without B test char at BAR
// RQ5 - Address-less format branches to held A_OPERAND_ADDRESS_REG
// RQ6 - Word-mark bit never affects branch decision
// RQ7 - Product discarded, memory never written
// RQ8 - A loads low part, keeps high bits
// RQ9 - Taken: BAR gets SR; else BAR=B-1
// RQ10 - Two-address set word mark at A, B
// RQ11 - Single-address set word mark; both A-1
// RQ12 - Address-less ops use A_OPERAND_ADDRESS_REG, BAR; decrement
// RQ13 - Extraction ends after B, no mark needed
// RQ14 - Set item mark at one or two places
// RQ15 - Two-address clear word mark at A, B
// RQ16 - Single-address clear word mark only at A
// RQ17 - Two-address clear item mark at both
// RQ18 - Single-address clear item mark; both A-1
// RQ19 - Programs should test one bit per branch
// RQ20 - Data, word, item bits written separately
`timescale 1ns/1ps
`include "bbm_map.vh"

module bbm_exec #(
    parameter AW  = 15,
    parameter FW  = 12,
    parameter MAW = 12
) (
    input  wire        clk_in,
    input  wire        rst_b_in,
    input  wire [5:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    output reg  [31:0] avs_readdata_out,
    output reg         avs_waitrequest_out,
    output reg         busy_out,
    output reg         branch_taken_out
);

    localparam S_IDLE = 2'h0;
    localparam S_EXTR = 2'h1;
    localparam S_EXEC = 2'h2;

    // Three separate arrays so each mark bit is written on its own
    reg [5:0]     mem_data [0:(1<<MAW)-1];  // see RQ20
    reg           mem_wm   [0:(1<<MAW)-1];  // see RQ20
    reg           mem_im   [0:(1<<MAW)-1];  // see RQ20

    reg [1:0]     state;
    reg [2:0]     op;
    reg [1:0]     fmt;
    reg [FW-1:0]  a_field;
    reg [FW-1:0]  b_field;
    reg [5:0]     v_field;
    reg [AW-1:0]  sequence_register;
    reg [AW-1:0]  a_operand_address_reg;
    reg [AW-1:0]  b_operand_address_reg;
    reg [5:0]     variant_reg;
    reg [MAW-1:0] mem_addr;
    reg           done_flag;

    wire          bus_req;
    wire          bus_wr;
    wire          is_branch;
    wire          has_a;
    wire          has_b;
    wire          has_v;
    wire          is_set;
    wire          is_wm;
    wire          two_loc;
    wire [MAW-1:0] a_idx;
    wire [MAW-1:0] b_idx;
    wire [5:0]    product;
    wire [AW-1:0] a_minus;
    wire [AW-1:0] b_minus;
    reg  [31:0]   next_readdata;
    wire          wr_idle;
    wire          wr_cmd;
    wire          wr_afield;
    wire          wr_bfield;
    wire          wr_vfield;
    wire          wr_seq;
    wire          wr_aaddr;
    wire          wr_baddr;
    wire          wr_vreg;
    wire          wr_maddr;
    wire          start_cmd;
    wire          in_extr;
    wire          in_exec;
    wire          taken_now;

    assign bus_req   = avs_read_in | avs_write_in;
    // Write lands only at the edge where waitrequest is seen low
    assign bus_wr    = avs_write_in & ~avs_waitrequest_out;
    assign is_branch = (op == `BBM_OP_BBA);
    assign has_a     = is_branch ? (fmt != `BBM_FMT_D)
                                 : (fmt != `BBM_FMT_C);
    assign has_b     = is_branch ? (fmt == `BBM_FMT_A) ||
                                   (fmt == `BBM_FMT_B)
                                 : (fmt == `BBM_FMT_A);
    assign has_v     = is_branch & (fmt == `BBM_FMT_A);
    assign is_set    = (op == `BBM_OP_SWM) || (op == `BBM_OP_SIM);
    assign is_wm     = (op == `BBM_OP_SWM) || (op == `BBM_OP_CWM);
    assign two_loc   = (fmt != `BBM_FMT_B);
    assign a_idx     = a_operand_address_reg[MAW-1:0];
    assign b_idx     = b_operand_address_reg[MAW-1:0];
    // Only the data array is read, so the word mark cannot count
    assign product   = mem_data[b_idx] & variant_reg;  // see RQ6
    assign a_minus   = a_operand_address_reg - {{(AW-1){1'b0}}, 1'b1};
    assign b_minus   = b_operand_address_reg - {{(AW-1){1'b0}}, 1'b1};
    // Registers move under software only while idle
    assign wr_idle   = bus_wr & (state == S_IDLE);
    assign wr_cmd    = wr_idle & (avs_address_in == `BBM_OFS_CMD);
    assign wr_afield = wr_idle & (avs_address_in == `BBM_OFS_AFIELD);
    assign wr_bfield = wr_idle & (avs_address_in == `BBM_OFS_BFIELD);
    assign wr_vfield = wr_idle & (avs_address_in == `BBM_OFS_VFIELD);
    assign wr_seq    = wr_idle & (avs_address_in == `BBM_OFS_SEQ);
    assign wr_aaddr  = wr_idle & (avs_address_in == `BBM_OFS_AADDR);
    assign wr_baddr  = wr_idle & (avs_address_in == `BBM_OFS_BADDR);
    assign wr_vreg   = wr_idle & (avs_address_in == `BBM_OFS_VREG);
    // Memory pointer stays writable so memory loads while busy
    assign wr_maddr  = bus_wr & (avs_address_in == `BBM_OFS_MADDR);
    assign start_cmd = wr_cmd & avs_writedata_in[`BBM_CMD_START];
    assign in_extr   = (state == S_EXTR);
    assign in_exec   = (state == S_EXEC);
    // Any set bit branches
    assign taken_now = in_exec & is_branch & (product != 6'h00);  // see RQ1

    // Bus slave: one wait cycle, then waitrequest low for one cycle
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h00000000;
        end else begin
            avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
            if (bus_req && avs_waitrequest_out) begin
                avs_readdata_out <= next_readdata;
            end
        end
    end

    always @* begin
        next_readdata = 32'h00000000;
        case (avs_address_in)
            `BBM_OFS_CMD: begin
                next_readdata[`BBM_CMD_OP_HI:`BBM_CMD_OP_LO]   = op;
                next_readdata[`BBM_CMD_FMT_HI:`BBM_CMD_FMT_LO] = fmt;
            end
            `BBM_OFS_AFIELD: next_readdata[FW-1:0] = a_field;
            `BBM_OFS_BFIELD: next_readdata[FW-1:0] = b_field;
            `BBM_OFS_VFIELD: next_readdata[5:0]    = v_field;
            `BBM_OFS_SEQ:    next_readdata[AW-1:0] = sequence_register;
            `BBM_OFS_AADDR:  next_readdata[AW-1:0] = a_operand_address_reg;
            `BBM_OFS_BADDR:  next_readdata[AW-1:0] = b_operand_address_reg;
            `BBM_OFS_VREG:   next_readdata[5:0]    = variant_reg;
            `BBM_OFS_MADDR:  next_readdata[MAW-1:0] = mem_addr;
            `BBM_OFS_MDATA: begin
                next_readdata[`BBM_MD_DATA_HI:0] = mem_data[mem_addr];
                next_readdata[`BBM_MD_WM]        = mem_wm[mem_addr];
                next_readdata[`BBM_MD_IM]        = mem_im[mem_addr];
            end
            `BBM_OFS_STATUS: begin
                next_readdata[`BBM_ST_BUSY]  = busy_out;
                next_readdata[`BBM_ST_TAKEN] = branch_taken_out;
                next_readdata[`BBM_ST_DONE]  = done_flag;
            end
            default: next_readdata = 32'h00000000;
        endcase
    end

    // Data array: the branch test never writes it
    always @(posedge clk_in) begin
        if (bus_wr && avs_address_in == `BBM_OFS_MDATA) begin
            mem_data[mem_addr] <= avs_writedata_in[`BBM_MD_DATA_HI:0];
        end
    end  // see RQ7

    // Word-mark array: only word-mark ops touch it
    always @(posedge clk_in) begin
        if (bus_wr && avs_address_in == `BBM_OFS_MDATA) begin
            mem_wm[mem_addr] <= avs_writedata_in[`BBM_MD_WM];
        end
        if (state == S_EXEC && !is_branch && is_wm) begin
            mem_wm[a_idx] <= is_set;  // see RQ10 see RQ11 see RQ15 see RQ16
            if (two_loc) begin
                mem_wm[b_idx] <= is_set;  // see RQ10 see RQ12 see RQ15
            end
        end
    end

    // Item-mark array: every non-branch op except the word-mark ones touches it
    always @(posedge clk_in) begin
        if (bus_wr && avs_address_in == `BBM_OFS_MDATA) begin
            mem_im[mem_addr] <= avs_writedata_in[`BBM_MD_IM];
        end
        if (state == S_EXEC && !is_branch && !is_wm) begin
            mem_im[a_idx] <= is_set;  // see RQ14 see RQ17 see RQ18
            if (two_loc) begin
                mem_im[b_idx] <= is_set;  // see RQ14 see RQ17 see RQ12
            end
        end
    end

    // Sequencer and status flags
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            state            <= S_IDLE;
            busy_out         <= 1'b0;
            branch_taken_out <= 1'b0;
            done_flag        <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (start_cmd) begin
                        state            <= S_EXTR;
                        busy_out         <= 1'b1;
                        branch_taken_out <= 1'b0;
                        done_flag        <= 1'b0;
                    end
                end
                S_EXTR: begin
                    // Extraction stops after B; no closing mark sought
                    state <= S_EXEC;  // see RQ13
                end
                S_EXEC: begin
                    if (taken_now) begin
                        branch_taken_out <= 1'b1;  // see RQ1
                    end
                    busy_out  <= 1'b0;
                    done_flag <= 1'b1;
                    state     <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Command and instruction fields
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            op      <= `BBM_OP_BBA;
            fmt     <= `BBM_FMT_A;
            a_field <= {FW{1'b0}};
            b_field <= {FW{1'b0}};
            v_field <= `BBM_RST_CHAR;
        end else begin
            if (wr_cmd) begin
                op  <= avs_writedata_in[`BBM_CMD_OP_HI:`BBM_CMD_OP_LO];
                fmt <= avs_writedata_in[`BBM_CMD_FMT_HI:`BBM_CMD_FMT_LO];
            end
            if (wr_afield) begin
                a_field <= avs_writedata_in[FW-1:0];
            end
            if (wr_bfield) begin
                b_field <= avs_writedata_in[FW-1:0];
            end
            if (wr_vfield) begin
                v_field <= avs_writedata_in[5:0];
            end
        end
    end

    // Sequence register: only a software write while idle or a taken branch moves it
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            sequence_register <= `BBM_RST_ADDR;
        end else if (wr_seq) begin
            sequence_register <= avs_writedata_in[AW-1:0];
        end else if (taken_now) begin
            sequence_register <= a_operand_address_reg;  // see RQ5
        end
    end

    // A operand address register
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            a_operand_address_reg <= `BBM_RST_ADDR;
        end else if (wr_aaddr) begin
            a_operand_address_reg <= avs_writedata_in[AW-1:0];
        end else if (in_extr && has_a) begin
            // Short field overlays low part of the register
            a_operand_address_reg[FW-1:0] <= a_field;  // see RQ8
        end else if (in_exec && !is_branch) begin
            a_operand_address_reg <= a_minus;  // see RQ12
        end
    end

    // B operand address register
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            b_operand_address_reg <= `BBM_RST_ADDR;
        end else if (wr_baddr) begin
            b_operand_address_reg <= avs_writedata_in[AW-1:0];
        end else if (in_extr && has_b) begin
            // Without B the register keeps its held address
            b_operand_address_reg[FW-1:0] <= b_field;  // see RQ4
        end else if (in_exec) begin
            if (is_branch) begin
                if (taken_now) begin
                    b_operand_address_reg <= sequence_register;  // see RQ9
                end else begin
                    b_operand_address_reg <= b_minus;  // see RQ2 see RQ9
                end
            end else if (two_loc) begin
                b_operand_address_reg <= b_minus;  // see RQ14
            end else begin
                b_operand_address_reg <= a_minus;  // see RQ11 see RQ18
            end
        end
    end

    // Variant register: retained unless the format carries one
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            variant_reg <= `BBM_RST_CHAR;
        end else if (wr_vreg) begin
            variant_reg <= avs_writedata_in[5:0];
        end else if (in_extr && has_v) begin
            variant_reg <= v_field;  // see RQ3
        end
    end

    // Memory pointer for software loads and checks
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            mem_addr <= {MAW{1'b0}};
        end else if (wr_maddr) begin
            mem_addr <= avs_writedata_in[MAW-1:0];
        end
    end

endmodule // bbm_exec
